// ---- rtl/asn_pkg.sv ----
// Package of constants and carrier types for the nibble static memory controller.
// What the document says
// R1: A write happens only while select and write strobe are both low.
// R2: Controller lowers both select and strobe to start any write.
// R3: Device ends the write when select or strobe rises first.
// R4: Data setup and hold are timed to the strobe edge ending the write.
// R5: Strobe stays high in reads; data shows only with select and drive low.
// R6: Data valid within 10 ns of stable address; reads spaced 10 ns apart.
// R7: Device holds old read data at least 3 ns after address change.
// R8: Device gives valid data within 10 ns after select falls.
// R9: Data valid 5 ns after drive falls; lines float 5 ns after it rises.
// R10: Device enters standby within 10 ns of deselect, wakes at once.
// R11: Address stable 7 ns before write end; strobe pulse 7 ns; writes 10 ns apart.
// R12: Address stable at write start and held until write end.
// R13: Write data placed 5 ns before write end, held until write end.
// R14: Strobe write with drive low lasts float delay plus data setup.
// R15: With drive high the device keeps its data lines floating in writes.
// R16: Select and strobe rising together leave device outputs floating.
// R17: Controller never drives data lines while device outputs are active.
// R18: Address valid no later than select falling in select-started reads.
// R19: Controller deselects before retention entry, with zero minimum delay.
// R20: Selected with drive and strobe high, device floats its data lines.
// R21: After retention recovery wait one read period before next access.
package asn_pkg;
    localparam int CLK_PERIOD_NS          = 10;
    localparam int READ_PERIOD_NS         = 10;
    localparam int ADDR_TO_DATA_DELAY_NS  = 10;
    localparam int SELECT_TO_DATA_DELAY_NS = 10;
    localparam int DRIVE_TO_DATA_DELAY_NS = 5;
    localparam int WRITE_PERIOD_NS        = 10;
    localparam int ADDR_SETUP_TO_END_NS   = 7;
    localparam int STROBE_PULSE_WIDTH_NS  = 7;
    localparam int WDATA_SETUP_NS         = 5;
    localparam int STROBE_TO_FLOAT_DELAY_NS = 5;
    localparam int DESELECT_TO_RETENTION_NS = 0;
    localparam int POWER_UP_US            = 100;

    // Ceiling for least times, at least one cycle.
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Read data must first pass both synchroniser stages; one more cycle covers pad delay.
    localparam int READ_WAIT_CYC  = cyc_min(ADDR_TO_DATA_DELAY_NS) + 3;
    localparam int READ_GAP_CYC   = cyc_min(READ_PERIOD_NS);
    localparam int STROBE_CYC     = cyc_min(STROBE_PULSE_WIDTH_NS + STROBE_TO_FLOAT_DELAY_NS);
    localparam int WRITE_GAP_CYC  = cyc_min(WRITE_PERIOD_NS);
    localparam int RECOVER_CYC    = cyc_min(READ_PERIOD_NS);
    localparam int POWER_UP_CYC   = POWER_UP_US * 1000 / CLK_PERIOD_NS;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 4;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asn_req_s;

    typedef struct packed {
        logic              sel_n;
        logic              drive_n;
        logic              strobe_n;
        logic [ADDR_W-1:0] addr;
    } asn_pins_s;
endpackage

// ---- rtl/asn_ctrl.sv ----
// Controller that sequences the select, drive and write strobe pins of the memory.
`timescale 1ns/1ns
module asn_ctrl #(
    parameter int POWER_UP_CYC = asn_pkg::POWER_UP_CYC  // Wait after supply settles.
) (
    input  wire logic                         clk,           // 100 MHz clock.
    input  wire logic                         rst,           // Synchronous reset, high.
    input  wire asn_pkg::asn_req_s            req,           // Access request.
    input  wire logic                         req_valid,     // Request offered.
    output logic                              req_ready,     // Request taken this cycle.
    output logic [asn_pkg::DATA_W-1:0]        rdata,         // Read result.
    output logic                              rdata_valid,   // One-cycle read result pulse.
    output logic                              wr_done,       // One-cycle write end pulse.
    input  wire logic                         retain_req,    // Ask for retention.
    output logic                              retain_ok,     // Device deselected, safe.
    output asn_pkg::asn_pins_s                pins,          // Select, drive, strobe, address.
    output logic [asn_pkg::DATA_W-1:0]        data_lines_o,  // Write data out.
    output logic                              data_lines_oe_n, // Low while we drive.
    input  wire logic [asn_pkg::DATA_W-1:0]   data_lines_i   // Data from the pins.
);
    // Refuse a power wait that the counter cannot serve.
    if (POWER_UP_CYC < 1) begin : g_bad_power_up
        $error("POWER_UP_CYC must be at least one");
    end

    // Read data crosses two synchroniser stages, so a shorter wait would take stale data.
    if (asn_pkg::READ_WAIT_CYC < 3) begin : g_bad_read_wait
        $error("READ_WAIT_CYC must cover the synchroniser");
    end

    typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_RD, ST_WR, ST_WEND, ST_GAP, ST_RET} asn_st_e;

    asn_st_e                   st_q, st_d;
    logic [31:0]               cnt_q, cnt_d;
    asn_pkg::asn_pins_s        pins_d;
    logic [asn_pkg::DATA_W-1:0] sync1_q, sync2_q;
    logic                      ret_sync1_q, ret_sync2_q;

    // Two-stage synchronisers for pin data and the retention request.
    always_ff @(posedge clk) begin
        sync1_q     <= data_lines_i;
        sync2_q     <= sync1_q;
        ret_sync1_q <= retain_req;
        ret_sync2_q <= ret_sync1_q;
    end

    wire cnt_done = (cnt_q == 32'h0000_0000);
    wire take     = (st_q == ST_IDLE) && req_valid && !ret_sync2_q;
    // Named decodes: wr_start for the sequencer and bus driver, rd_capture for the output registers.
    wire wr_start   = take && req.wr;
    wire rd_capture = (st_q == ST_RD) && cnt_done;

    // Sequencer: every write lowers select and strobe together and raises them together.
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_done ? cnt_q : cnt_q - 32'h0000_0001;
        pins_d = pins;
        case (st_q)
            ST_PWR: begin
                if (cnt_done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                pins_d = '{sel_n: 1'b1, drive_n: 1'b1, strobe_n: 1'b1, addr: pins.addr};
                if (ret_sync2_q) begin
                    st_d = ST_RET; // R19
                end else if (wr_start) begin
                    // Address settles with select and strobe falling; drive stays high. R12 R14
                    pins_d = '{sel_n: 1'b0, drive_n: 1'b1, strobe_n: 1'b0, addr: req.addr}; // R1 R2
                    cnt_d  = 32'(asn_pkg::STROBE_CYC - 1); // R11 R13
                    st_d   = ST_WR;
                end else if (take) begin
                    // Address valid together with select falling, strobe high. R18
                    pins_d = '{sel_n: 1'b0, drive_n: 1'b0, strobe_n: 1'b1, addr: req.addr}; // R5
                    cnt_d  = 32'(asn_pkg::READ_WAIT_CYC - 1); // R6
                    st_d   = ST_RD;
                end
            end
            ST_RD: begin
                if (cnt_done) begin
                    pins_d.sel_n   = 1'b1;
                    pins_d.drive_n = 1'b1;
                    cnt_d = 32'(asn_pkg::READ_GAP_CYC - 1); // R6
                    st_d  = ST_GAP;
                end
            end
            ST_WR: begin
                if (cnt_done) begin
                    // Both strobes rise together; data and address still held. R3 R4 R13
                    pins_d.sel_n    = 1'b1;
                    pins_d.strobe_n = 1'b1;
                    st_d = ST_WEND;
                end
            end
            ST_WEND: begin
                cnt_d = 32'(asn_pkg::WRITE_GAP_CYC - 1); // R11
                st_d  = ST_GAP;
            end
            ST_GAP: begin
                if (cnt_done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_RET: begin
                if (!ret_sync2_q) begin
                    cnt_d = 32'(asn_pkg::RECOVER_CYC - 1); // R21
                    st_d  = ST_GAP;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // State and pin registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= ST_PWR;
            cnt_q <= 32'(POWER_UP_CYC - 1);
            pins  <= '{sel_n: 1'b1, drive_n: 1'b1, strobe_n: 1'b1, addr: '0};
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            pins  <= pins_d;
        end
    end

    // Data bus driver: only in write states, so never against device outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_lines_oe_n <= 1'b1;
            data_lines_o    <= '0;
        end else begin
            data_lines_oe_n <= !wr_start && (st_q != ST_WR); // R17
            data_lines_o    <= take ? req.wdata : data_lines_o;
        end
    end

    // Handshake and result strobes; read data taken while select and drive are still low.
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ready   <= 1'b0;
            rdata_valid <= 1'b0;
            wr_done     <= 1'b0;
            rdata       <= '0;
            retain_ok   <= 1'b0;
        end else begin
            req_ready   <= (st_d == ST_IDLE) && (st_q != ST_IDLE || !take);
            rdata_valid <= rd_capture;
            wr_done     <= (st_q == ST_WEND);
            if (rd_capture) begin
                rdata <= sync2_q; // R9
            end
            retain_ok   <= (st_q == ST_RET) && pins.sel_n; // R19
        end
    end

    // Write: select and strobe stay low together for the whole pulse.
    property p_wr_pair;
        @(posedge clk) disable iff (rst)
        (st_q == ST_WR) |-> (!pins.sel_n && !pins.strobe_n && pins.drive_n);
    endproperty
    a_wr_pair: assert property (p_wr_pair) else $error("write strobes not paired"); // R1

    property p_rd_strobe;
        @(posedge clk) disable iff (rst)
        (st_q == ST_RD) |-> pins.strobe_n && !pins.sel_n;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read"); // R5

    property p_no_clash;
        @(posedge clk) disable iff (rst)
        !pins.drive_n |-> data_lines_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("bus clash"); // R17

    property p_end_together;
        @(posedge clk) disable iff (rst)
        ($rose(pins.strobe_n) && st_q == ST_WEND) |-> $rose(pins.sel_n);
    endproperty
    a_end_together: assert property (p_end_together) else $error("write end split"); // R3

    property p_ret_desel;
        @(posedge clk) disable iff (rst)
        retain_ok |-> pins.sel_n;
    endproperty
    a_ret_desel: assert property (p_ret_desel) else $error("retention while selected"); // R19

    // Our write data is on the lines for the whole strobe pulse.
    property p_wr_drive;
        @(posedge clk) disable iff (rst)
        (st_q == ST_WR) |-> !data_lines_oe_n;
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not driven"); // R13

    // Data and address still stand at the edge where the strobes rise.
    property p_wr_hold;
        @(posedge clk) disable iff (rst)
        $rose(pins.strobe_n) |-> !data_lines_oe_n && $stable(pins.addr) && $stable(data_lines_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write end data moved"); // R4 R12

    // The strobe pulse spans two cycles, well over the least pulse width.
    property p_wr_pulse;
        @(posedge clk) disable iff (rst)
        $fell(pins.strobe_n) |-> (!pins.strobe_n) [*2];
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("strobe pulse too short"); // R11

    // Select stays high for a cycle after each access, so cycles never crowd.
    property p_desel_gap;
        @(posedge clk) disable iff (rst)
        $rose(pins.sel_n) |=> pins.sel_n;
    endproperty
    a_desel_gap: assert property (p_desel_gap) else $error("access gap too short"); // R6

    // In retention the device stays deselected and we keep off the lines.
    property p_ret_float;
        @(posedge clk) disable iff (rst)
        (st_q == ST_RET) |-> pins.sel_n && data_lines_oe_n;
    endproperty
    a_ret_float: assert property (p_ret_float) else $error("active in retention"); // R19

    // After retention ends, select stays high for the recovery time.
    property p_recover;
        @(posedge clk) disable iff (rst)
        (st_q == ST_RET && !ret_sync2_q) |=> pins.sel_n ##1 pins.sel_n;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery wait too short"); // R21
endmodule

// ---- dv/asn_mem_model.sv ----
// Behavioural model of the nibble static memory on the far side of the controller.
`timescale 1ns/1ns
module asn_mem_model (
    input  wire asn_pkg::asn_pins_s         pins,      // Strobes and address.
    input  wire logic [asn_pkg::DATA_W-1:0] ctrl_data, // Controller write data.
    input  wire logic                       ctrl_oe_n, // Low while the controller drives.
    output logic [asn_pkg::DATA_W-1:0]      wire_data, // Resolved level of the lines.
    output int                              clash      // Times both sides drove at once.
);
    logic [asn_pkg::DATA_W-1:0] mem [int];
    logic [asn_pkg::DATA_W-1:0] last;
    logic [asn_pkg::DATA_W-1:0] wd = '0;
    int                         wa;
    logic                       wr_win;
    logic                       dev_drive;

    // The write window is the overlap of select low and strobe low.
    assign wr_win = !pins.sel_n && !pins.strobe_n;
    // Drive only in a read; writes, deselect and disabled drive float the lines.
    assign dev_drive = !pins.sel_n && !pins.drive_n && pins.strobe_n;

    // Capture inside the window and store when the first strobe rises.
    always @(pins or ctrl_data or wr_win) begin
        if (wr_win) begin
            wa = int'(pins.addr);
            wd = ctrl_data;
        end
    end
    always @(negedge wr_win) mem[wa] = wd;

    // No pull on these lines, so a released line shows the inverse of its last level.
    always @(pins or ctrl_data or ctrl_oe_n or dev_drive) begin
        if (!ctrl_oe_n && dev_drive) clash++;
        if (!ctrl_oe_n) last = ctrl_data;
        else if (dev_drive) last = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 4'h0;
        wire_data = (!ctrl_oe_n || dev_drive) ? last : ~last;
    end

    initial clash = 0;
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the nibble static memory controller.
`timescale 1ns/1ns
module tb;
    logic                       clk;
    logic                       rst;
    asn_pkg::asn_req_s          req;
    logic                       req_valid;
    logic                       req_ready;
    logic [asn_pkg::DATA_W-1:0] rdata;
    logic                       rdata_valid;
    logic                       wr_done;
    logic                       retain_req;
    logic                       retain_ok;
    asn_pkg::asn_pins_s         pins;
    logic [asn_pkg::DATA_W-1:0] dout;
    logic                       oe_n;
    logic [asn_pkg::DATA_W-1:0] din;
    int                         clash;
    int                         miscompares;
    int                         checked;
    logic [19:0]                ta [4] = '{20'h00000, 20'hFFFFF, 20'h5A5A5, 20'h12345};
    logic [3:0]                 td [4] = '{4'hF, 4'h0, 4'hA, 4'h5};

    asn_ctrl #(.POWER_UP_CYC(4)) dut_u (.clk(clk), .rst(rst), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
        .rdata_valid(rdata_valid), .wr_done(wr_done), .retain_req(retain_req),
        .retain_ok(retain_ok), .pins(pins), .data_lines_o(dout),
        .data_lines_oe_n(oe_n), .data_lines_i(din));
    asn_mem_model mem_u (.pins(pins), .ctrl_data(dout), .ctrl_oe_n(oe_n),
        .wire_data(din), .clash(clash));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Offer one request, hold it through the taking edge, then wait for its pulse.
    task automatic access(input logic wr, input logic [19:0] a, input logic [3:0] d);
        int n;
        @(negedge clk);
        req = '{wr: wr, addr: a, wdata: d};
        req_valid = 1'b1;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 20 && (wr ? wr_done : rdata_valid) !== 1'b1; n++) @(negedge clk);
        chk_bit(wr ? wr_done : rdata_valid, 1'h1);
    endtask

    // A read only while the strobe is high; a write window always has our data out.
    always @(negedge clk) begin
        if (!rst && !pins.sel_n && !pins.drive_n) chk_bit(pins.strobe_n, 1'h1);
        if (!rst && !pins.sel_n && !pins.strobe_n) chk_bit(oe_n, 1'h0);
    end

    // Boundary addresses, then an overwrite read straight back.
    task automatic t_write_read;
        for (int i = 0; i < 4; i++) access(1'b1, ta[i], td[i]);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, ta[i], 4'h0);
            chk(rdata, td[i]);
        end
        access(1'b1, ta[2], 4'h3);
        access(1'b0, ta[2], 4'h0);
        chk(rdata, 4'h3);
        chk_bit(pins.sel_n, 1'h1);
    endtask

    // Retention holds the device deselected and refuses requests meanwhile.
    task automatic t_retention;
        int n;
        @(negedge clk);
        retain_req = 1'b1;
        for (n = 0; n < 20 && retain_ok !== 1'b1; n++) @(negedge clk);
        chk_bit(retain_ok, 1'h1);
        chk_bit(pins.sel_n, 1'h1);
        req_valid = 1'b1;
        repeat (5) begin
            @(negedge clk);
            chk_bit(req_ready, 1'h0);
        end
        req_valid = 1'b0;
        retain_req = 1'b0;
        access(1'b0, ta[1], 4'h0);
        chk(rdata, td[1]);
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        req_valid = 1'b0;
        retain_req = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_write_read();
        t_retention();
        chk_cnt(clash, 0);
        summarize();
    end

    // The whole run needs about a hundred cycles; cut a hang well beyond that.
    initial begin
        #30000;
        miscompares++;
        summarize();
    end
endmodule
